// File: include/gdss_pkg.sv
// constants for the pin direction and source select block
package gdss_pkg;
    localparam int          NUM_PINS        = 32;
    localparam int          HALF_PINS       = 16;
    localparam logic [11:0] PIN_CFG_LOW_OFS  = 12'h31c;
    localparam logic [11:0] PIN_CFG_HIGH_OFS = 12'h320;
    localparam logic [11:0] DEBOUNCE_OFS     = 12'h324;
    localparam logic [11:0] IN_DATA_LOW_OFS  = 12'h328;
    localparam logic [11:0] IN_DATA_HIGH_OFS = 12'h32c;
    localparam logic [11:0] OUT_DATA_LOW_OFS = 12'h330;
    localparam logic [11:0] OUT_DATA_HIGH_OFS = 12'h334;
    localparam logic [31:0] PIN_CFG_RESET    = 32'h0000_0000;
    localparam logic [31:0] DEBOUNCE_RESET   = 32'h0000_0000;
    localparam logic [31:0] OUT_DATA_RESET   = 32'h0000_0000;
    localparam logic [2:0]  OWNER_PORT       = 3'h0;
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          DEB_TIME_NS      = 1600;
    localparam int          DEB_CYCLES       = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DEB_CNT_W        = 5;
    localparam logic [DEB_CNT_W-1:0] DEB_LIMIT = DEB_CNT_W'(DEB_CYCLES);
endpackage

// File: include/gdss_deb_if.sv
// carrier between the register core and the per-pin input filter
`timescale 1ns/1ns
`default_nettype none
interface gdss_deb_if;
    logic [31:0] raw;
    logic [31:0] enable;
    logic [31:0] clean;
    modport ctrl (output raw, output enable, input clean);
    modport filt (input raw, input enable, output clean);
endinterface
`default_nettype wire

// File: rtl/gdss_debounce.sv
// per-pin input filter: level must hold a fixed time before it passes
`timescale 1ns/1ns
`default_nettype none
module gdss_debounce (
    input  wire logic   clk,
    input  wire logic   reset_n,
    gdss_deb_if.filt    deb
);
    genvar i;
    generate
        for (i = 0; i < gdss_pkg::NUM_PINS; i++) begin : g_pin
            logic [gdss_pkg::DEB_CNT_W-1:0] cnt_r;
            logic                           clean_r;
            wire  logic                     differs = deb.raw[i] != clean_r;
            wire  logic                     settled = cnt_r == gdss_pkg::DEB_LIMIT - 1'b1;
            // debounce gate
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    cnt_r   <= '0;
                    clean_r <= 1'b0;
                end else if (!deb.enable[i]) begin
                    cnt_r   <= '0;
                    clean_r <= deb.raw[i];
                end else if (!differs) begin
                    cnt_r   <= '0;
                end else if (settled) begin
                    cnt_r   <= '0;
                    clean_r <= deb.raw[i];
                end else begin
                    cnt_r   <= cnt_r + 1'b1;
                end
            end
            assign deb.clean[i] = clean_r;
        end
    endgenerate
endmodule
`default_nettype wire

// File: rtl/gdss_top.sv
// pin direction, source select, data and debounce registers of port 0
`timescale 1ns/1ns
`default_nettype none
module gdss_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [2:0]  cfg_port,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output var  logic [31:0] cfg_rdata,
    output var  logic        cfg_rvalid,
    input  wire logic [31:0] pin_in,
    output var  logic [31:0] pin_out,
    output var  logic [31:0] pin_oe,
    output var  logic        host_irq
);
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] cfg_low_r;
    logic [31:0] cfg_high_r;
    logic [31:0] deb_en_r;
    logic [31:0] out_low_r;
    logic [31:0] out_high_r;

    // only the first port owns these words
    wire logic mine    = cfg_port == gdss_pkg::OWNER_PORT;
    wire logic wr_ok   = cfg_wr && mine;
    wire logic rd_ok   = cfg_rd && mine;
    wire logic hit_cl  = cfg_addr == gdss_pkg::PIN_CFG_LOW_OFS;
    wire logic hit_ch  = cfg_addr == gdss_pkg::PIN_CFG_HIGH_OFS;
    wire logic hit_db  = cfg_addr == gdss_pkg::DEBOUNCE_OFS;
    wire logic hit_il  = cfg_addr == gdss_pkg::IN_DATA_LOW_OFS;
    wire logic hit_ih  = cfg_addr == gdss_pkg::IN_DATA_HIGH_OFS;
    wire logic hit_ol  = cfg_addr == gdss_pkg::OUT_DATA_LOW_OFS;
    wire logic hit_oh  = cfg_addr == gdss_pkg::OUT_DATA_HIGH_OFS;

    // per-pin fields pulled out of the two config words and the two data words
    logic [31:0] sel_w;
    logic [31:0] dir_w;
    logic [31:0] out_w;
    genvar n;
    generate
        for (n = 0; n < gdss_pkg::HALF_PINS; n++) begin : g_field
            assign sel_w[n] = cfg_low_r[2*n];
            assign dir_w[n] = cfg_low_r[2*n+1];
            assign sel_w[n+16] = cfg_high_r[2*n];
            assign dir_w[n+16] = cfg_high_r[2*n+1];
            assign out_w[n] = out_low_r[n];
            assign out_w[n+16] = out_high_r[n];
        end
    endgenerate

    gdss_deb_if deb ();
    assign deb.raw    = pin_in;
    assign deb.enable = deb_en_r & ~dir_w;

    gdss_debounce u_deb (
        .clk     (clk),
        .reset_n (reset_n),
        .deb     (deb.filt)
    );

    wire logic [31:0] in_view  = deb.clean & ~dir_w;
    wire logic        irq_nxt  = |(deb.clean & ~dir_w & sel_w);
    // reserved select drives low rather than stale data
    wire logic [31:0] out_nxt  = out_w & ~sel_w;
    wire logic [31:0] oe_nxt   = dir_w;

    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_cl) begin
            rdata_nxt = cfg_low_r;
        end else if (hit_ch) begin
            rdata_nxt = cfg_high_r;
        end else if (hit_db) begin
            rdata_nxt = deb_en_r;
        end else if (hit_il) begin
            // inputs of either select land in the data word
            rdata_nxt = {16'h0000, in_view[15:0]};
        end else if (hit_ih) begin
            rdata_nxt = {16'h0000, in_view[31:16]};
        end else if (hit_ol) begin
            rdata_nxt = {16'h0000, out_low_r[15:0]};
        end else if (hit_oh) begin
            rdata_nxt = {16'h0000, out_high_r[15:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_low_r  <= gdss_pkg::PIN_CFG_RESET;
            cfg_high_r <= gdss_pkg::PIN_CFG_RESET;
            deb_en_r   <= gdss_pkg::DEBOUNCE_RESET;
            out_low_r  <= gdss_pkg::OUT_DATA_RESET;
            out_high_r <= gdss_pkg::OUT_DATA_RESET;
        end else if (wr_ok) begin
            if (hit_cl) cfg_low_r  <= be_merge(cfg_low_r, cfg_wdata, cfg_be);
            if (hit_ch) cfg_high_r <= be_merge(cfg_high_r, cfg_wdata, cfg_be);
            if (hit_db) deb_en_r   <= be_merge(deb_en_r, cfg_wdata, cfg_be);
            // data words hold 16 pins; upper half stays zero
            if (hit_ol) out_low_r  <= be_merge(out_low_r, cfg_wdata, cfg_be) & 32'h0000_ffff;
            if (hit_oh) out_high_r <= be_merge(out_high_r, cfg_wdata, cfg_be) & 32'h0000_ffff;
        end
    end

    // reads from other ports answer zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            cfg_rdata  <= rd_ok ? rdata_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_out  <= 32'h0000_0000;
            pin_oe   <= 32'h0000_0000;
            host_irq <= 1'b0;
        end else begin
            pin_out  <= out_nxt;
            pin_oe   <= oe_nxt;
            host_irq <= irq_nxt;
        end
    end
endmodule
`default_nettype wire

// File: bench/gdss_checker.sv
// port assertions for the pin direction and source select block
`timescale 1ns/1ns
`default_nettype none
module gdss_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [2:0]  cfg_port,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_rvalid,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic        host_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    function automatic logic [15:0] dirs(input logic [31:0] w);
        for (int i = 0; i < 16; i++) dirs[i] = w[2*i+1];
    endfunction
    // a later write to the same word would mask the first one
    wire w0  = cfg_wr && cfg_port == 3'h0;
    wire wcl = w0 && cfg_addr == 12'h31c;
    wire wch = w0 && cfg_addr == 12'h320;
    wire wod = w0 && cfg_addr == 12'h330;
    chk_rv_follow: assert property (cfg_rd |=> cfg_rvalid) else $error("read got no rvalid");
    chk_rv_alone: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray rvalid");
    chk_port_fence: assert property (cfg_rd && cfg_port != 3'h0 |=> cfg_rdata == 32'h0)
        else $error("foreign port read not zero");
    chk_dir_low: assert property (wcl ##1 !cfg_wr |=>
        pin_oe[15:0] == dirs($past(cfg_wdata, 2))) else $error("low direction bits wrong");
    chk_dir_high: assert property (wch ##1 !cfg_wr |=>
        pin_oe[31:16] == dirs($past(cfg_wdata, 2))) else $error("high direction bits wrong");
    chk_out_data: assert property (wod ##1 !cfg_wr |=>
        (pin_out[15:0] & ~$past(cfg_wdata[15:0], 2)) == 16'h0)
        else $error("pin driven high without data bit");
    chk_irq_out: assert property ((pin_oe == 32'hffff_ffff) [*3] |-> !host_irq)
        else $error("interrupt with every pin an output");
    chk_rst_quiet: assert property (disable iff (1'b0)
        !reset_n |=> pin_oe == 32'h0 && !host_irq) else $error("outputs active after reset");
    cover property (wcl);
    cover property (host_irq);
    cover property (cfg_rd && cfg_port != 3'h0);
    cover property (pin_oe == 32'hffff_ffff);
endmodule
`default_nettype wire

// File: bench/gdss_board.sv
// board side of the pins: driven pins read back, the rest follow ext
`timescale 1ns/1ns
`default_nettype none
module gdss_board (
    input  wire logic [31:0] ext,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    output var  logic [31:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// File: bench/gdss_top_bench.sv
// self-checking bench for the pin direction and source select block
`timescale 1ns/1ns
`default_nettype none
module gdss_top_bench;
    logic        clk = 1'b0, reset_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_rvalid, host_irq;
    logic [2:0]  cfg_port = 3'h0;
    logic [3:0]  cfg_be = 4'hf;
    logic [11:0] cfg_addr = 12'h0;
    logic [31:0] cfg_wdata = 32'h0, ext = 32'h0, cfg_rdata, pin_in, pin_out, pin_oe;
    int          mismatches = 0, n_tests = 0;
    initial forever #50 clk = ~clk;
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        final_report();
    end
    gdss_top dut (.clk(clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .host_irq(host_irq));
    gdss_board board (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one access; a read compares its data against d
    task automatic acc(input logic w, input logic [2:0] p, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        {cfg_port, cfg_addr, cfg_wdata} = {p, a, d};
        cfg_wr = w;
        cfg_rd = !w;
        @(negedge clk);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        if (!w) check(cfg_rdata, d);
    endtask
    task automatic final_report;
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        acc(1'b0, 3'h0, 12'h31c, 32'h0);
        acc(1'b1, 3'h0, 12'h31c, 32'h8000_0018);
        acc(1'b1, 3'h0, 12'h330, 32'hffff_ffff);
        acc(1'b0, 3'h0, 12'h330, 32'h0000_ffff);
        check(pin_oe, 32'h0000_8002);
        ext = 32'hffff_aaaa;
        acc(1'b0, 3'h0, 12'h328, 32'h0000_2aa8);
        acc(1'b1, 3'h0, 12'h324, 32'h0000_0008);
        ext = 32'hffff_aaa2;
        acc(1'b0, 3'h0, 12'h328, 32'h0000_2aa8);
        repeat (20) @(negedge clk);
        acc(1'b0, 3'h0, 12'h328, 32'h0000_2aa0);
        check({31'h0, host_irq}, 32'h0);
        ext = 32'hffff_aaa6;
        repeat (4) @(negedge clk);
        check({31'h0, host_irq}, 32'h1);
        acc(1'b1, 3'h0, 12'h320, 32'h0000_0008);
        acc(1'b1, 3'h0, 12'h334, 32'h0000_0002);
        acc(1'b0, 3'h0, 12'h32c, 32'h0000_fffd);
        check(pin_out & pin_oe, 32'h0002_8002);
        acc(1'b1, 3'h1, 12'h31c, 32'hffff_ffff);
        acc(1'b0, 3'h0, 12'h31c, 32'h8000_0018);
        acc(1'b0, 3'h1, 12'h31c, 32'h0);
        // single lane write must leave the other lanes alone
        cfg_be = 4'h2;
        acc(1'b1, 3'h0, 12'h324, 32'hffff_ffff);
        cfg_be = 4'hf;
        acc(1'b0, 3'h0, 12'h324, 32'h0000_ff08);
        acc(1'b1, 3'h0, 12'h31c, 32'haaaa_aaaa);
        acc(1'b1, 3'h0, 12'h320, 32'haaaa_aaaa);
        acc(1'b0, 3'h0, 12'h328, 32'h0);
        // let every pin sit as output long enough for the checker
        repeat (4) @(negedge clk);
        check({31'h0, host_irq}, 32'h0);
        // mid-run reset must clear configured words
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check(pin_oe, 32'h0);
        acc(1'b0, 3'h0, 12'h320, 32'h0);
        final_report();
    end
endmodule
bind gdss_top gdss_checker chk (.clk(clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .pin_out(pin_out), .pin_oe(pin_oe), .host_irq(host_irq));
`default_nettype wire
